// ==== quad_dac_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the quad converter front end.
`ifndef QUAD_DAC_REGS_SVH
`define QUAD_DAC_REGS_SVH

`define CTRL_OFS       12'h000
`define WORD_OFS       12'h004
`define CODE_OFS_BASE  12'h008
`define CODE_OFS_STEP  12'h004
`define CODE_REG_COUNT 4'h8

`define CTRL_RST       2'h0
`define CTRL_FORCE_BIT 0
`define CTRL_BLOCK_BIT 1

`define ZERO_CODE      12'h000
`define MID_CODE       12'h800

`define WORD_BITS      16
`define ADDR_HI_POS    15
`define ADDR_LO_POS    14
`define CODE_MSB_POS   11

`define SYNC_STAGES    3
`define APB_WAIT       1

`endif

// ==== quad_dac_pkg.sv ====
// Types shared by the quad converter front end.
package quad_dac_pkg;

    typedef logic [11:0]      code_t;
    typedef logic [3:0][11:0] code_arr_t;
    typedef logic [15:0]      word_t;

    typedef enum logic [2:0] {
        SYN_IN_LATCH,
        SYN_DAC_LATCH,
        SYN_CODE_SEL,
        SYN_RESET,
        SYN_TOGGLE
    } sync_idx_e;

    typedef struct packed {
        logic [4:0][2:0] sync;
        logic [4:0]      filt;
        logic            tgl_seen;
        word_t           word;
        code_arr_t       in_reg;
        code_arr_t       dac_reg;
        logic [1:0]      ctrl;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
    } core_s;

    typedef struct packed {
        word_t word;
        logic  tgl;
    } link_s;

endpackage

// ==== shift_link_if.sv ====
// Carrier for the shifted word and its shift event between the link and system domains.
`timescale 1ns/1ps
interface shift_link_if;
    logic [15:0] word;
    logic        tgl;
    modport src (output word, output tgl);
    modport dst (input word, input tgl);
endinterface

// ==== serial_shifter.sv ====
// Serial-to-parallel shift register running on the combined select and serial clock.
`timescale 1ns/1ps
module serial_shifter (
    input  wire logic   shift_clk,
    input  wire logic   rst,
    input  wire logic   serial_data_in,
    shift_link_if.src   lnk
);
    import quad_dac_pkg::*;

    link_s q;
    link_s d;

    // Every rising edge advances one bit; newest bit enters at the bottom.
    always_comb begin
        d      = q;
        d.word = {q.word[14:0], serial_data_in};
        d.tgl  = ~q.tgl;
    end

    always_ff @(posedge shift_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lnk.word = q.word;
    assign lnk.tgl  = q.tgl;

    shift_step_a: assert property (@(posedge shift_clk) disable iff (rst)
        1'b1 |=> (q.word[15:1] == $past(q.word[14:0])) && (q.tgl != $past(q.tgl)))
        else $error("shift register did not advance by one bit");

endmodule

// ==== quad_dac_core.sv ====
// Quad 12-bit converter digital front end: serial load, double buffering and APB view.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "quad_dac_regs.svh"
module quad_dac_core (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   serial_clk,
    input  wire logic                   select_n,
    input  wire logic                   serial_data_in,
    input  wire logic                   input_latch_strobe_n,
    input  wire logic                   dac_latch_strobe_n,
    input  wire logic                   reset_code_select,
    input  wire logic                   dac_reset_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output quad_dac_pkg::code_arr_t     dac_code
);
    import quad_dac_pkg::*;

    core_s       q;
    core_s       n;

    logic        shift_clk;
    logic [4:0]  pin_vec;
    logic        force_rst;
    code_t       rst_code;
    logic [1:0]  load_ch;
    code_t       load_code;
    logic [3:0]  rsel;
    logic        access;

    shift_link_if lnk ();

    // The select and serial clock are combined exactly as the pins are, so
    // either one may serve as the shift clock and a select rise while the
    // clock is low costs one extra shift. That is why the host must raise
    // select only with the clock high.
    assign shift_clk = select_n | serial_clk;

    serial_shifter shifter (
        .shift_clk      (shift_clk),
        .rst            (rst),
        .serial_data_in (serial_data_in),
        .lnk            (lnk.src)
    );

    // Maps a bus address to a register slot; 4'hF marks an unmapped address.
    function automatic logic [3:0] reg_slot(input logic [11:0] a);
        reg_slot = 4'hF;
        if (a == `CTRL_OFS) begin
            reg_slot = 4'h0;
        end else if (a == `WORD_OFS) begin
            reg_slot = 4'h1;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (a == `CODE_OFS_BASE + 12'(i) * `CODE_OFS_STEP) begin
                    reg_slot = 4'(i + 2);
                end
            end
        end
    endfunction

    // Picks the reset code from the filtered code select pin.
    function automatic code_t reset_value(input logic sel);
        reset_value = sel ? `MID_CODE : `ZERO_CODE;
    endfunction

    assign pin_vec[SYN_IN_LATCH]  = input_latch_strobe_n;
    assign pin_vec[SYN_DAC_LATCH] = dac_latch_strobe_n;
    assign pin_vec[SYN_CODE_SEL]  = reset_code_select;
    assign pin_vec[SYN_RESET]     = dac_reset_n;
    assign pin_vec[SYN_TOGGLE]    = lnk.tgl;

    assign access = psel && penable && !q.pready;
    assign rsel   = reg_slot(paddr);

    always_comb begin
        n         = q;
        force_rst = 1'b0;
        rst_code  = `ZERO_CODE;
        load_ch   = 2'h0;
        load_code = `ZERO_CODE;

        // Pins and the shift event pass three stages; a new level counts
        // only once the second and third stages agree, so a single
        // metastable sample never reaches the converter registers.
        for (int i = 0; i < `SYNC_STAGES + 2; i++) begin
            n.sync[i] = {q.sync[i][1:0], pin_vec[i]};
            if (q.sync[i][1] == q.sync[i][2]) begin
                n.filt[i] = q.sync[i][2];
            end
        end

        // The shifted word is copied once its shift event has crossed. The
        // copy is safe because the shortest clock period the host may use
        // is far longer than the three-stage crossing delay.
        if (q.filt[SYN_TOGGLE] != q.tgl_seen) begin
            n.tgl_seen = q.filt[SYN_TOGGLE];
            n.word     = lnk.word;
        end

        load_ch   = {q.word[`ADDR_HI_POS], q.word[`ADDR_LO_POS]};
        load_code = q.word[`CODE_MSB_POS:0];
        rst_code  = reset_value(q.filt[SYN_CODE_SEL]);
        force_rst = !q.filt[SYN_RESET] || q.ctrl[`CTRL_FORCE_BIT];

        // The forced reset wins over both strobes. The shifted word is left
        // alone, and once reset lifts nothing reloads a latched register.
        if (force_rst) begin
            for (int c = 0; c < 4; c++) begin
                n.in_reg[c]  = rst_code;
                n.dac_reg[c] = rst_code;
            end
        end else begin
            if (!q.filt[SYN_IN_LATCH] && !q.ctrl[`CTRL_BLOCK_BIT]) begin
                n.in_reg[load_ch] = load_code;
            end
            if (!q.filt[SYN_DAC_LATCH]) begin
                n.dac_reg = q.in_reg;
            end
        end

        // APB: each access phase is answered one cycle after it begins.
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        if (access) begin
            n.pready = 1'b1;
            n.prdata = 32'h0000_0000;
            if (rsel == 4'hF) begin
                n.pslverr = 1'b1;
            end else if (pwrite) begin
                // Control writes are committed at the answer edge, below.
            end else if (rsel == 4'h0) begin
                n.prdata = {30'h0000_0000, q.ctrl};
            end else if (rsel == 4'h1) begin
                n.prdata = {16'h0000, q.word};
            end else if (rsel < 4'h6) begin
                n.prdata = {20'h00000, q.dac_reg[2'(rsel - 4'h2)]};
            end else begin
                n.prdata = {20'h00000, q.in_reg[2'(rsel - 4'h6)]};
            end
        end

        // A write lands at the edge at which the master sees pready high, so
        // an access that the master abandons early leaves the control bits alone.
        if (psel && penable && pwrite && q.pready && rsel == 4'h0 && pstrb[0]) begin
            n.ctrl = pwdata[1:0];
        end
    end

    // Reset values: strobes and the device reset idle high, so nothing loads
    // or forces until the pins have actually been sampled.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q          <= '0;
            q.sync     <= {3'h0, 3'h7, 3'h0, 3'h7, 3'h7};
            q.filt     <= {1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
            q.ctrl     <= `CTRL_RST;
        end else begin
            q <= n;
        end
    end

    assign prdata   = q.prdata;
    assign pready   = q.pready;
    assign pslverr  = q.pslverr;
    assign dac_code = q.dac_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    force_zero_a: assert property (
        (!q.filt[SYN_RESET] && !q.filt[SYN_CODE_SEL])
        |=> (q.in_reg == '0) && (q.dac_reg == '0))
        else $error("reset did not force the zero code");

    force_mid_a: assert property (
        (!q.filt[SYN_RESET] && q.filt[SYN_CODE_SEL])
        |=> (q.in_reg == {4{`MID_CODE}}) && (q.dac_reg == {4{`MID_CODE}}))
        else $error("reset did not force the mid code");

    dac_hold_a: assert property (
        (q.filt[SYN_DAC_LATCH] && !force_rst) |=> $stable(q.dac_reg))
        else $error("latched converter register changed");

    dac_follow_a: assert property (
        (!q.filt[SYN_DAC_LATCH] && !force_rst) |=> (q.dac_reg == $past(q.in_reg)))
        else $error("transparent converter register did not follow");

    input_hold_a: assert property (
        (q.filt[SYN_IN_LATCH] && !force_rst) |=> $stable(q.in_reg))
        else $error("latched input register changed");

    input_load_a: assert property (
        (!q.filt[SYN_IN_LATCH] && !q.ctrl[1] && !force_rst)
        |=> (q.in_reg[$past(load_ch)] == $past(q.word[11:0])))
        else $error("addressed input register not loaded with the code");

    unaddressed_hold_a: assert property (
        (!force_rst && load_ch != 2'h0) |=> $stable(q.in_reg[0]))
        else $error("unaddressed channel A input register changed");

    reset_release_a: assert property (
        ($rose(q.filt[SYN_RESET]) && q.filt[SYN_DAC_LATCH] && !q.ctrl[0])
        |-> (q.dac_reg == $past(q.dac_reg)) ##1 $stable(q.dac_reg))
        else $error("latched register lost its reset code after release");

    word_capture_a: assert property (
        (q.filt[SYN_TOGGLE] != q.tgl_seen) |=> (q.word == $past(lnk.word)))
        else $error("shifted word not captured on its shift event");

    apb_answer_a: assert property (
        (psel && penable && !q.pready) |=> q.pready ##1 !q.pready)
        else $error("APB answer not a single cycle after access start");

    apb_error_a: assert property (
        (access && rsel == 4'hF) |=> (q.pslverr && q.prdata == 32'h0000_0000))
        else $error("unmapped address not refused");

    // Forced reset and the shifted word. The forced code must come from the
    // code select as it stood one cycle earlier, since the force itself is
    // registered; the shifted word may only move on a crossed shift event.

    force_code_a: assert property (
        force_rst
        |=> (q.in_reg == $past({4{rst_code}})) && (q.dac_reg == $past({4{rst_code}})))
        else $error("forced reset did not load the selected code");

    word_kept_a: assert property (
        (force_rst && q.filt[SYN_TOGGLE] == q.tgl_seen)
        |=> $stable(q.word))
        else $error("forced reset disturbed the shifted word");

    word_idle_a: assert property (
        (q.filt[SYN_TOGGLE] == q.tgl_seen)
        |=> $stable(q.word))
        else $error("shifted word changed without a shift event");

    tgl_track_a: assert property (
        (q.filt[SYN_TOGGLE] != q.tgl_seen)
        |=> (q.tgl_seen == $past(q.filt[SYN_TOGGLE])))
        else $error("shift event not marked as seen");

    // Pin filters: a level only counts once two stages agree, so a single
    // unsettled sample can never flip a strobe or the device reset.

    reset_filter_a: assert property (
        (q.sync[SYN_RESET][1] != q.sync[SYN_RESET][2])
        |=> $stable(q.filt[SYN_RESET]))
        else $error("device reset taken before two stages agreed");

    strobe_filter_a: assert property (
        (q.sync[SYN_IN_LATCH][1] != q.sync[SYN_IN_LATCH][2])
        |=> $stable(q.filt[SYN_IN_LATCH]))
        else $error("input strobe taken before two stages agreed");

    load_block_a: assert property (
        (q.ctrl[`CTRL_BLOCK_BIT] && !force_rst)
        |=> $stable(q.in_reg))
        else $error("input register loaded while loads are blocked");

    chan_b_hold_a: assert property (
        (!force_rst && load_ch != 2'h1)
        |=> $stable(q.in_reg[1]))
        else $error("unaddressed channel B input register changed");

    chan_c_hold_a: assert property (
        (!force_rst && load_ch != 2'h2)
        |=> $stable(q.in_reg[2]))
        else $error("unaddressed channel C input register changed");

    chan_d_hold_a: assert property (
        (!force_rst && load_ch != 2'h3)
        |=> $stable(q.in_reg[3]))
        else $error("unaddressed channel D input register changed");

    // Bus view. Read data is held between answers so that a slow master
    // may still pick it up; the control bits move only on a completed write.

    apb_idle_a: assert property (
        !(psel && penable)
        |=> !q.pready)
        else $error("APB answer without an access phase");

    apb_ok_a: assert property (
        (access && rsel != 4'hF)
        |=> !q.pslverr)
        else $error("mapped address refused");

    ctrl_write_a: assert property (
        (psel && penable && pwrite && q.pready && rsel == 4'h0 && pstrb[0])
        |=> (q.ctrl == $past(pwdata[1:0])))
        else $error("control write did not land at the answer edge");

    ctrl_hold_a: assert property (
        !(psel && penable && pwrite && q.pready)
        |=> $stable(q.ctrl))
        else $error("control bits changed without a completed write");

    prdata_hold_a: assert property (
        !access
        |=> $stable(q.prdata))
        else $error("read data changed outside an answer");

    word_read_a: assert property (
        (access && !pwrite && rsel == 4'h1)
        |=> (q.prdata == {16'h0000, $past(q.word)}))
        else $error("word read did not return the captured word");

    dac_read_a: assert property (
        (access && !pwrite && rsel == 4'h2)
        |=> (q.prdata == {20'h00000, $past(q.dac_reg[0])}))
        else $error("channel A code read did not return its register");

endmodule

// ==== quad_dac_host.sv ====
// Host model that shifts words into the converter front end.
`timescale 1ns/1ps
module quad_dac_host (
    output logic serial_clk,
    output logic select_n,
    output logic serial_data_in
);
    // Select and clock idle high, so strobes and resets never see a false shift edge.
    initial {serial_clk, select_n, serial_data_in} = 3'h6;
    task automatic send(input logic [15:0] w, input bit cs);
        if (cs) serial_clk = 1'b0;
        else select_n = 1'b0;
        #55;
        for (int i = 15; i >= 0; i--) begin
            if (cs) select_n = 1'b0;
            else serial_clk = 1'b0;
            serial_data_in = w[i];
            #50;
            if (cs) select_n = 1'b1;
            else serial_clk = 1'b1;
            #30;
        end
        {serial_clk, select_n} = 2'h3;
        #20;
        // The data line has no pull, so after hold time it shows the opposite level.
        serial_data_in = ~serial_data_in;
    endtask
endmodule

// ==== tb_quad_dac_core.sv ====
// Self-checking bench for the quad converter front end.
`timescale 1ns/1ps
`include "quad_dac_regs.svh"
module tb_quad_dac_core;
    import quad_dac_pkg::*;
    logic        mclk, rst, serial_clk, select_n, serial_data_in, err;
    logic        ld_n, dac_n, csel, drst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    code_arr_t   dac_code;
    word_t       last_w;
    code_t       cv [4] = '{12'h5A3, 12'hC3F, 12'hFFF, 12'h001};
    int          n_mismatch, n_compared, cycles;
    quad_dac_host host (.serial_clk, .select_n, .serial_data_in);
    quad_dac_core dut (.mclk, .rst, .serial_clk, .select_n, .serial_data_in,
        .input_latch_strobe_n(ld_n), .dac_latch_strobe_n(dac_n), .reset_code_select(csel),
        .dac_reset_n(drst_n), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
        .prdata, .pready, .pslverr, .dac_code);
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // The planned traffic needs about 1400 cycles; the ceiling leaves a wide margin.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Codes are sampled mid-cycle, clear of the register updates at the edge.
    task automatic chk_dac(string nm, code_arr_t e);
        @(negedge mclk);
        for (int i = 0; i < 4; i++) chk(nm, 32'(e[i]), 32'(dac_code[i]));
        @(posedge mclk);
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge mclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        // The answer is taken at the rising edge at which pready stands high.
        do @(posedge mclk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    task automatic rdchk(string nm, logic [11:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic load(word_t w, bit cs);
        host.send(w, cs);
        last_w = w;
        cyc(6);
        ld_n <= 1'b0;
        cyc(10);
        ld_n <= 1'b1;
        cyc(10);
    endtask
    task automatic t_load;
        for (int i = 0; i < 4; i++) begin
            load({2'(i), 2'h3, cv[i]}, i == 1);
            rdchk("input", 12'h018 + 12'(4 * i), 32'(cv[i]));
        end
        for (int i = 0; i < 4; i++) rdchk("kept", 12'h018 + 12'(4 * i), 32'(cv[i]));
        rdchk("word", `WORD_OFS, 32'(last_w));
        chk_dac("latched", '0);
        dac_n <= 1'b0;
        cyc(10);
        chk_dac("open", {cv[3], cv[2], cv[1], cv[0]});
        dac_n <= 1'b1;
        cyc(10);
        $display("end load");
    endtask
    task automatic t_rst;
        for (int s = 0; s < 2; s++) begin
            csel <= 1'(s);
            cyc(6);
            drst_n <= 1'b0;
            cyc(10);
            chk_dac("reset", {4{s ? `MID_CODE : `ZERO_CODE}});
            drst_n <= 1'b1;
            cyc(10);
            rdchk("in_reset", 12'h018, s ? 32'h800 : 32'h0);
            chk_dac("held", {4{s ? `MID_CODE : `ZERO_CODE}});
            rdchk("word_kept", `WORD_OFS, 32'(last_w));
        end
        $display("end reset");
    endtask
    task automatic t_follow;
        dac_n <= 1'b0;
        load(16'h87E4, 1'b0);
        chk_dac("follow", {`MID_CODE, 12'h7E4, `MID_CODE, `MID_CODE});
        dac_n <= 1'b1;
        $display("end follow");
    endtask
    task automatic t_bus;
        rdchk("ctrl_rst", `CTRL_OFS, 32'(`CTRL_RST));
        apb(1'b0, 12'h030, 32'h0);
        chk("unmapped_err", 32'h1, 32'(err));
        chk("unmapped_data", 32'h0, rd);
        apb(1'b1, `WORD_OFS, 32'h1234);
        rdchk("word_ro", `WORD_OFS, 32'(last_w));
        apb(1'b1, `CTRL_OFS, 32'h2);
        rdchk("ctrl_rw", `CTRL_OFS, 32'h2);
        load(16'h0ABC, 1'b0);
        rdchk("blocked", 12'h018, 32'h800);
        apb(1'b1, `CTRL_OFS, 32'h1);
        cyc(2);
        chk_dac("forced", {4{`MID_CODE}});
        rdchk("in_forced", 12'h020, 32'h800);
        apb(1'b1, `CTRL_OFS, 32'h0);
        rdchk("ctrl_clear", `CTRL_OFS, 32'h0);
        $display("end bus");
    endtask
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h0, 32'h0};
        {ld_n, dac_n, csel, drst_n} = 4'hD;
        cyc(20);
        rst <= 1'b0;
        chk_dac("after_rst", '0);
        t_load();
        t_rst();
        t_follow();
        t_bus();
        report_and_stop();
    end
endmodule
